// ==== adc_core_calibration_sequencer.sv ====
`timescale 1ns/1ns
`include "cal_seq_consts.svh"
module adc_core_calibration_sequencer #(
  parameter logic [15:0] CAL_PHASE_CYCLES = `CAL_PHASE_CYCLES
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [31:0]                 wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic [31:0]                      wb_dat_o,
  output logic                             wb_ack_o,
  output logic                             irq_o,
  input  wire logic                        external_cal_trigger_pin_i,
  input  wire cal_seq_pkg::trim_s [7:0]    factory_trim_i,
  input  wire cal_seq_pkg::sample_t [5:0]  core_sample_i,
  output cal_seq_pkg::sample_t [3:0]       chan_sample_o,
  output logic [5:0]                       core_online_o,
  output logic [5:0]                       core_cal_o,
  output logic [5:0][2:0]                  core_input_o,
  output logic                             cal_ref_en_o,
  output logic                             cal_done_o,
  output cal_seq_pkg::trim_s [7:0]         trim_o
);
  import cal_seq_pkg::*;

  function automatic logic core_used(input logic [1:0] v, input logic [2:0] c);
    core_used = (v == `VAR_QUAD) ? (c < 3'h6) :
                (v == `VAR_DUAL) ? (c < 3'h3) : (c == 3'h0 || c == 3'h2);
  endfunction : core_used

  function automatic logic [2:0] next_core(input logic [1:0] v, input logic [2:0] from);
    next_core = `NO_CORE;
    for (int i = 5; i >= 0; i--) begin
      if (3'(i) >= from && core_used(v, 3'(i))) next_core = 3'(i);
    end
  endfunction : next_core

  function automatic logic chan_used(input logic [1:0] v, input logic [1:0] ch);
    chan_used = (v == `VAR_QUAD) || (v == `VAR_DUAL && ch < 2'h2) || ch == 2'h0;
  endfunction : chan_used

  ctrl_s        ctrl;
  logic [1:0]   irq_status;
  logic [1:0]   irq_mask;
  logic [7:0]   core_source_switch_delay;
  logic [7:0]   output_mux_switch_delay;
  trim_s [7:0]  trim;
  seq_state_e   state;
  logic [2:0]   eng_core;
  logic         eng_start, eng_busy, eng_done;
  logic [7:0]   dly_cnt;
  logic [2:0]   pin_sync;
  logic         pin_level, trig_prev, fg_pending, bg_group;
  logic [1:0]   grp_next;
  logic [2:0]   grp_spare [2];
  logic [3:0][2:0] chan_core;
  logic [1:0]   tgt_ch;
  logic [2:0]   spare_now, fg_next;
  logic         bg_mode, trig_lvl, access, mapped, trim_hit, swap_done;
  logic [9:0]   idx;
  logic [31:0]  rdata;
  logic [1:0]   irq_set;
  logic [5:0]   next_online;

  // register bus
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx    = wb_adr_i[11:2];
  assign mapped = (wb_adr_i[31:12] == 20'h00000);
  assign trim_hit = (idx[9:3] == 7'(`TRIM_BASE_IDX >> 3));

  always_comb begin
    rdata = 32'h0000_0000;
    if (!mapped) begin
      rdata = 32'h0000_0000;
    end else if (idx == `CTRL_IDX) begin
      rdata = {25'h0000000, ctrl};
    end else if (idx == `STATUS_IDX) begin
      rdata = {26'h0000000, eng_core, state == SEQ_FG_RUN, bg_mode, cal_done_o};
    end else if (idx == `IRQ_STATUS_IDX) begin
      rdata = {30'h00000000, irq_status};
    end else if (idx == `IRQ_MASK_IDX) begin
      rdata = {30'h00000000, irq_mask};
    end else if (idx == `SRC_DLY_IDX) begin
      rdata = {24'h000000, core_source_switch_delay};
    end else if (idx == `MUX_DLY_IDX) begin
      rdata = {24'h000000, output_mux_switch_delay};
    end else if (trim_hit) begin
      rdata = {8'h00, trim[idx[2:0]]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      if (access && !wb_we_i) wb_dat_o <= rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl                     <= `CTRL_RESET;
      irq_mask                 <= 2'h0;
      core_source_switch_delay <= `SW_DLY_RESET;
      output_mux_switch_delay  <= `SW_DLY_RESET;
    end else if (access && wb_we_i && mapped && wb_sel_i[0]) begin
      if (idx == `CTRL_IDX) begin
        ctrl <= ctrl_s'(wb_dat_i[6:0]);
      end else if (idx == `IRQ_MASK_IDX) begin
        irq_mask <= wb_dat_i[1:0];
      end else if (idx == `SRC_DLY_IDX) begin
        core_source_switch_delay <= wb_dat_i[7:0];
      end else if (idx == `MUX_DLY_IDX) begin
        output_mux_switch_delay <= wb_dat_i[7:0];
      end
    end
  end

  // trim per input and core pairing; offset held by calibration when enabled
  assign trim_o = trim;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trim <= factory_trim_i;
    end else if (access && wb_we_i && mapped && trim_hit) begin
      trim[idx[2:0]].termination <= wb_sel_i[2] ? wb_dat_i[23:16] : trim[idx[2:0]].termination;
      trim[idx[2:0]].gain        <= wb_sel_i[1] ? wb_dat_i[15:8] : trim[idx[2:0]].gain;
      if (!ctrl.foreground_offset_cal_enable && !ctrl.background_offset_cal_enable) begin
        trim[idx[2:0]].offset <= wb_sel_i[0] ? wb_dat_i[7:0] : trim[idx[2:0]].offset;
      end
    end
  end

  // interrupts: read of status clears, set wins
  assign swap_done = (state == SEQ_BG_MUX) && (dly_cnt == output_mux_switch_delay);
  assign irq_set   = {swap_done, state == SEQ_FG_RUN && eng_done && fg_next == `NO_CORE};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= 2'h0;
    end else if (access && !wb_we_i && mapped && idx == `IRQ_STATUS_IDX) begin
      irq_status <= irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // trigger pin synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_sync  <= 3'h0;
      pin_level <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], external_cal_trigger_pin_i};
      if (pin_sync[1] == pin_sync[2]) pin_level <= pin_sync[2];
    end
  end

  assign trig_lvl = ctrl.cal_trigger_source_select ? pin_level : ctrl.software_cal_trigger;
  assign bg_mode  = ctrl.background_cal_enable && !ctrl.cal_trigger_source_select
                    && ctrl.software_cal_trigger;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_prev  <= 1'b0;
      fg_pending <= 1'b1;
    end else begin
      trig_prev <= trig_lvl;
      if (trig_lvl && !trig_prev && !bg_mode) begin
        fg_pending <= 1'b1;
      end else if (state == SEQ_IDLE) begin
        fg_pending <= 1'b0;
      end
    end
  end

  // sequencer
  assign fg_next   = next_core(ctrl.variant, eng_core + 3'h1);
  assign tgt_ch    = {bg_group, (ctrl.variant == `VAR_SINGLE) ? 1'b0 : grp_next[bg_group]};
  assign spare_now = grp_spare[bg_group];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= SEQ_IDLE;
      eng_core  <= 3'h0;
      eng_start <= 1'b0;
    end else begin
      eng_start <= 1'b0;
      case (state)
        SEQ_IDLE: begin
          if (fg_pending) begin
            state     <= SEQ_FG_RUN;
            eng_core  <= next_core(ctrl.variant, 3'h0);
            eng_start <= 1'b1;
          end else if (bg_mode) begin
            state     <= SEQ_BG_CAL;
            eng_core  <= spare_now;
            eng_start <= 1'b1;
          end
        end
        SEQ_FG_RUN: begin
          if (eng_done && fg_next == `NO_CORE) begin
            state <= SEQ_IDLE;
          end else if (eng_done) begin
            eng_core  <= fg_next;
            eng_start <= 1'b1;
          end
        end
        SEQ_BG_CAL: if (eng_done) state <= SEQ_BG_SRC;
        SEQ_BG_SRC: if (dly_cnt == core_source_switch_delay) state <= SEQ_BG_MUX;
        SEQ_BG_MUX: if (swap_done) state <= SEQ_IDLE;
        default: state <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (state != SEQ_BG_SRC && state != SEQ_BG_MUX)) begin
      dly_cnt <= 8'h00;
    end else if (state == SEQ_BG_SRC && dly_cnt == core_source_switch_delay) begin
      dly_cnt <= 8'h00;
    end else begin
      dly_cnt <= dly_cnt + 8'h01;
    end
  end

  // core map: spare 2 serves channels a/b, spare 3 serves c/d
  always_ff @(posedge clk_i) begin
    if (rst_i || state == SEQ_FG_RUN) begin
      chan_core    <= {3'h5, 3'h4, 3'h1, 3'h0};
      grp_spare[0] <= 3'h2;
      grp_spare[1] <= 3'h3;
      grp_next     <= 2'h0;
      bg_group     <= 1'b0;
      core_input_o <= {3'h3, 3'h2, `NO_INPUT, `NO_INPUT, 3'h1, 3'h0};
    end else if (state == SEQ_BG_SRC && dly_cnt == core_source_switch_delay) begin
      core_input_o[spare_now] <= {1'b0, tgt_ch};
    end else if (swap_done) begin
      chan_core[tgt_ch]          <= spare_now;
      grp_spare[bg_group]        <= chan_core[tgt_ch];
      core_input_o[chan_core[tgt_ch]] <= `NO_INPUT;
      grp_next[bg_group]         <= !grp_next[bg_group];
      bg_group                   <= (ctrl.variant == `VAR_QUAD) ? !bg_group : 1'b0;
    end
  end

  always_comb begin
    next_online = 6'h00;
    for (int c = 0; c < 4; c++) begin
      if (chan_used(ctrl.variant, 2'(c))) next_online[chan_core[c]] = 1'b1;
    end
  end

  // sample outputs; swap glitches accepted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_sample_o <= {4{`MID_CODE}};
      core_online_o <= 6'h00;
    end else begin
      for (int c = 0; c < 4; c++) begin
        chan_sample_o[c] <= (state == SEQ_FG_RUN || !chan_used(ctrl.variant, 2'(c))) ?
                            `MID_CODE : core_sample_i[chan_core[c]];
      end
      core_online_o <= (state == SEQ_FG_RUN) ? 6'h00 : next_online;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_cal_o   <= 6'h00;
      cal_ref_en_o <= 1'b0;
      cal_done_o   <= 1'b0;
    end else begin
      core_cal_o   <= (eng_busy || eng_start) ? 6'(6'h01 << eng_core) : 6'h00;
      cal_ref_en_o <= eng_busy || eng_start;
      if (state == SEQ_FG_RUN || fg_pending) begin
        cal_done_o <= 1'b0;
      end else if (state == SEQ_IDLE) begin
        cal_done_o <= 1'b1;
      end
    end
  end

  core_cal_engine engine (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .start_i     (eng_start),
    .ofs_en_i    (ctrl.foreground_offset_cal_enable || ctrl.background_offset_cal_enable),
    .phase_len_i (CAL_PHASE_CYCLES),
    .busy_o      (eng_busy),
    .done_o      (eng_done),
    .phase_o     ()
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence bg_cal_end_s;
    state == SEQ_BG_CAL && eng_done;
  endsequence
  sequence src_switch_s;
    state == SEQ_BG_SRC [*1] ##1 state inside {SEQ_BG_SRC, SEQ_BG_MUX};
  endsequence

  mid_code_a: assert property ($past(state == SEQ_FG_RUN) |-> chan_sample_o == '0)
    else $error("samples not mid-code during foreground calibration");
  cores_offline_a: assert property (state == SEQ_FG_RUN |=> core_online_o == 6'h00)
    else $error("core online during foreground calibration");
  powerup_fg_a: assert property ($fell(rst_i) |-> ##[0:2] state == SEQ_FG_RUN)
    else $error("no foreground calibration after reset");
  trigger_fg_a: assert property (fg_pending && state == SEQ_IDLE |=> state == SEQ_FG_RUN)
    else $error("trigger did not start foreground calibration");
  single_cal_a: assert property ($onehot0(core_cal_o))
    else $error("more than one core calibrating");
  swap_order_a: assert property (bg_cal_end_s |=> src_switch_s)
    else $error("calibrated spare not switched in");
  spare_offline_a: assert property (state == SEQ_BG_CAL && !$rose(state == SEQ_BG_CAL)
                                    |-> !next_online[eng_core])
    else $error("core under calibration carries output data");
  done_flag_a: assert property (state == SEQ_FG_RUN |=> !cal_done_o)
    else $error("complete flag high during foreground calibration");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held longer than one cycle");
endmodule : adc_core_calibration_sequencer

// ==== cal_seq_consts.svh ====
// Contract
// - foreground calibration takes active cores offline and drives mid-code samples
// - foreground mapping: core 0 input A, core 1 B, core 4 C, core 5 D
// - quad background: spare core 2 replaces 0 or 1, spare 3 replaces 4 or 5
// - dual: cores 0 and 1 share spare 2; single: core 0 uses spare 2
// - foreground calibration always runs after power-up; system waits before programming
// - trigger event starts foreground; source pin or software bit per select
// - background keeps converting: calibrate spare, then switch it in
// - rotation is continuous: recalibrated core replaces next active core
// - only one core is calibrated at any moment in background mode
// - each calibration trims linearity, gain and offset against internal reference; offset phase runs only when an offset cal enable bit is set
// - brief swap glitches on converted data are permitted behaviour
// - trim registers reset to factory values and are readable and writable; the offset field ignores writes while an offset cal enable bit is set
// - trim fields exist per sampled input and per core pairing
`ifndef CAL_SEQ_CONSTS_SVH
`define CAL_SEQ_CONSTS_SVH
`define CTRL_IDX        10'h000
`define STATUS_IDX      10'h001
`define IRQ_STATUS_IDX  10'h002
`define IRQ_MASK_IDX    10'h003
`define TRIM_BASE_IDX   10'h010
`define SRC_DLY_IDX     10'h09a
`define MUX_DLY_IDX     10'h09b
`define CTRL_RESET      7'h40
`define SW_DLY_RESET    8'h00
`define IRQ_FG_DONE     0
`define IRQ_SWAP        1
`define VAR_SINGLE      2'h0
`define VAR_DUAL        2'h1
`define VAR_QUAD        2'h2
`define MID_CODE        12'h000
`define NO_INPUT        3'h7
`define NO_CORE         3'h6
`define CAL_PHASE_CYCLES 16'h0100
`endif

// ==== cal_seq_pkg.sv ====
package cal_seq_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_FG_RUN,
    SEQ_BG_CAL,
    SEQ_BG_SRC,
    SEQ_BG_MUX
  } seq_state_e;
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_LIN,
    PH_GAIN,
    PH_OFS
  } cal_phase_e;
  typedef struct packed {
    logic [1:0] variant;
    logic       background_offset_cal_enable;
    logic       foreground_offset_cal_enable;
    logic       software_cal_trigger;
    logic       cal_trigger_source_select;
    logic       background_cal_enable;
  } ctrl_s;
  typedef struct packed {
    logic [7:0] termination;
    logic [7:0] gain;
    logic [7:0] offset;
  } trim_s;
  typedef logic [11:0] sample_t;
endpackage : cal_seq_pkg

// ==== cal_system_model.sv ====
`timescale 1ns/1ns
module cal_system_model (
  input  wire logic                    clk_i,
  output cal_seq_pkg::sample_t [5:0]   core_sample_o,
  output logic                         trigger_o
);
  import cal_seq_pkg::*;
  // each core shows its own fixed nonzero level, so any mute or mix-up shows
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      core_sample_o[k] = sample_t'(12'h111 * (k + 1));
    end
  end
  initial trigger_o = 1'b0;
  // pin held long enough to pass the synchroniser
  task automatic pulse(input int len);
    trigger_o <= 1'b1;
    repeat (len) @(posedge clk_i);
    trigger_o <= 1'b0;
  endtask : pulse
endmodule : cal_system_model

// ==== core_cal_engine.sv ====
`timescale 1ns/1ns
module core_cal_engine (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   start_i,
  input  wire logic                   ofs_en_i,
  input  wire logic [15:0]            phase_len_i,
  output logic                        busy_o,
  output logic                        done_o,
  output cal_seq_pkg::cal_phase_e     phase_o
);
  import cal_seq_pkg::*;

  logic [15:0] cnt;
  logic        last;

  assign last = (cnt == phase_len_i - 16'h0001);

  // phase walk against the internal reference
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_o <= PH_IDLE;
    end else begin
      case (phase_o)
        PH_IDLE: if (start_i) phase_o <= PH_LIN;
        PH_LIN:  if (last) phase_o <= PH_GAIN;
        PH_GAIN: if (last) phase_o <= ofs_en_i ? PH_OFS : PH_IDLE;
        PH_OFS:  if (last) phase_o <= PH_IDLE;
        default: phase_o <= PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || phase_o == PH_IDLE || last) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= last && (phase_o == PH_OFS || (phase_o == PH_GAIN && !ofs_en_i));
    end
  end

  assign busy_o = (phase_o != PH_IDLE);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  phase_order_a: assert property (done_o |-> $past(phase_o) inside {PH_GAIN, PH_OFS})
    else $error("calibration ended outside gain or offset phase");
  lin_first_a: assert property (phase_o == PH_IDLE && start_i |=> phase_o == PH_LIN)
    else $error("calibration did not begin with linearity");
endmodule : core_cal_engine

// ==== tb_adc_core_calibration_sequencer.sv ====
`timescale 1ns/1ns
`include "cal_seq_consts.svh"
module tb_adc_core_calibration_sequencer;
  import cal_seq_pkg::*;
  localparam logic [5:0]  ON [3]    = '{6'h01, 6'h03, 6'h33};
  localparam logic [5:0]  ALLOW [3] = '{6'h05, 6'h07, 6'h3f};
  localparam int          NACT [3]  = '{1, 2, 4};
  localparam logic [47:0] CHANS [3] = '{48'h111, 48'h222111, 48'h666555222111};
  logic             clk_i;
  logic             rst_i;
  logic             wb_cyc;
  logic             wb_stb;
  logic             wb_we;
  logic [31:0]      wb_adr;
  logic [31:0]      wb_wdat;
  logic [31:0]      wb_dat_o;
  logic             wb_ack_o;
  logic             irq_o;
  logic             trig_pin;
  trim_s [7:0]      factory;
  trim_s [7:0]      trim;
  sample_t [5:0]    core_sample;
  sample_t [3:0]    chan_sample_o;
  logic [5:0]       core_online_o;
  logic [5:0]       core_cal_o;
  logic [5:0][2:0]  core_input_o;
  logic             cal_ref_en_o;
  logic             cal_done_o;
  logic [31:0]      rd;
  logic             bg_watch;
  logic [5:0]       last_online;
  int               vsel;
  int               swaps;
  int               errors;
  int               checks_done;

  adc_core_calibration_sequencer #(.CAL_PHASE_CYCLES(16'h0004)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .external_cal_trigger_pin_i(trig_pin),
    .factory_trim_i(factory), .core_sample_i(core_sample), .chan_sample_o(chan_sample_o),
    .core_online_o(core_online_o), .core_cal_o(core_cal_o), .core_input_o(core_input_o),
    .cal_ref_en_o(cal_ref_en_o), .cal_done_o(cal_done_o), .trim_o(trim)
  );
  cal_system_model model (.clk_i(clk_i), .core_sample_o(core_sample), .trigger_o(trig_pin));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] ba(input logic [9:0] idx);
    return {20'h0, idx, 2'b00};
  endfunction : ba

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= wd;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 16) begin
      errors++;
    end
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(64'(rd), 64'(exp));
  endtask : rd_chk

  task automatic wait_flag(input logic want, input int lim);
    int n;
    n = 0;
    while (cal_done_o !== want && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    check(64'(cal_done_o), 64'(want));
  endtask : wait_flag

  // after a foreground run: active cores online and mapped to their inputs
  task automatic settle(input int v);
    wait_flag(1'b1, 2000);
    repeat (3) @(posedge clk_i);
    check(64'(core_online_o), 64'(ON[v]));
    check(64'(chan_sample_o), 64'(CHANS[v]));
  endtask : settle

  task automatic fg(input int v, input logic pin);
    logic [31:0] c;
    c = 32'(v) << 5;
    wb(1'b1, ba(`CTRL_IDX), c);
    if (pin) begin
      wb(1'b1, ba(`CTRL_IDX), c | 32'h2);
      model.pulse(8);
    end else begin
      wb(1'b1, ba(`CTRL_IDX), c | 32'h4);
    end
    wait_flag(1'b0, 20);
    for (int n = 0; n < 200 && core_online_o !== 6'h00; n++) begin
      @(posedge clk_i);
    end
    repeat (3) @(posedge clk_i);
    check(64'(chan_sample_o), 64'h0);
    check(64'(core_online_o), 64'h0);
    check(64'(cal_ref_en_o), 64'h1);
    settle(v);
  endtask : fg

  task automatic bg(input int v);
    logic [31:0] c;
    c = 32'(v) << 5;
    vsel = v;
    wb(1'b1, ba(`CTRL_IDX), c);
    wb(1'b1, ba(`CTRL_IDX), c | 32'h5);
    swaps = 0;
    bg_watch = 1'b1;
    repeat (600) @(posedge clk_i);
    bg_watch = 1'b0;
    check(64'(swaps >= 3), 64'h1);
    wb(1'b0, ba(`IRQ_STATUS_IDX), 32'h0);
    check(64'(rd[`IRQ_SWAP]), 64'h1);
  endtask : bg

  // continuous watch while background calibration rotates cores
  always @(posedge clk_i) begin
    if (bg_watch) begin
      check(64'(core_online_o & ~ALLOW[vsel]), 64'h0);
      check(64'($countones(core_online_o)), 64'(NACT[vsel]));
      check(64'(core_cal_o & (core_cal_o - 6'h01)), 64'h0);
      check(64'(chan_sample_o[0] == 12'h000), 64'h0);
      check(64'(core_input_o[2] inside {3'h0, 3'h1, 3'h7}), 64'h1);
      check(64'(core_input_o[3] inside {3'h2, 3'h3, 3'h7}), 64'h1);
      if (core_online_o !== last_online) begin
        swaps++;
      end
    end
    last_online <= core_online_o;
  end

  initial begin
    #200000;
    errors++;
    test_done();
  end

  initial begin
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 32'h0;
    wb_wdat = 32'h0;
    bg_watch = 1'b0;
    vsel = 2;
    errors = 0;
    checks_done = 0;
    for (int p = 0; p < 8; p++) begin
      factory[p] = trim_s'(24'h302010 + 24'h010101 * 24'(p));
    end
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(64'(cal_done_o), 64'h0);
    settle(2);
    rd_chk(ba(`CTRL_IDX), 32'(`CTRL_RESET));
    rd_chk(ba(`SRC_DLY_IDX), 32'h0);
    rd_chk(ba(`MUX_DLY_IDX), 32'h0);
    wb(1'b1, ba(`SRC_DLY_IDX), 32'h1f);
    wb(1'b1, ba(`MUX_DLY_IDX), 32'h1e);
    rd_chk(ba(`SRC_DLY_IDX), 32'h1f);
    rd_chk(ba(`MUX_DLY_IDX), 32'h1e);
    wb(1'b1, 32'h1000 | ba(`SRC_DLY_IDX), 32'h55);
    rd_chk(32'h1000 | ba(`SRC_DLY_IDX), 32'h0);
    rd_chk(ba(`SRC_DLY_IDX), 32'h1f);
    for (int p = 0; p < 8; p++) begin
      rd_chk(ba(`TRIM_BASE_IDX + 10'(p)), 32'(factory[p]));
    end
    wb(1'b1, ba(`TRIM_BASE_IDX + 10'h3), 32'h00abcdef);
    rd_chk(ba(`TRIM_BASE_IDX + 10'h3), 32'h00abcdef);
    check(64'(trim[3]), 64'h00abcdef);
    rd_chk(ba(`TRIM_BASE_IDX + 10'h4), 32'(factory[4]));
    wb(1'b1, ba(`CTRL_IDX), 32'h48);
    wb(1'b1, ba(`TRIM_BASE_IDX + 10'h3), 32'h00123456);
    rd_chk(ba(`TRIM_BASE_IDX + 10'h3), 32'h001234ef);
    wb(1'b1, ba(`CTRL_IDX), 32'h4c);
    wait_flag(1'b0, 20);
    settle(2);
    wb(1'b1, ba(`IRQ_MASK_IDX), 32'h0);
    repeat (2) @(posedge clk_i);
    check(64'(irq_o), 64'h0);
    wb(1'b1, ba(`IRQ_MASK_IDX), 32'h1);
    repeat (2) @(posedge clk_i);
    check(64'(irq_o), 64'h1);
    rd_chk(ba(`IRQ_STATUS_IDX), 32'h1);
    repeat (2) @(posedge clk_i);
    check(64'(irq_o), 64'h0);
    rd_chk(ba(`IRQ_STATUS_IDX), 32'h0);
    fg(2, 1'b0);
    fg(2, 1'b1);
    bg(2);
    for (int v = 1; v >= 0; v--) begin
      fg(v, 1'b0);
      bg(v);
    end
    test_done();
  end
endmodule : tb_adc_core_calibration_sequencer
